// file: pos_offset_sync.sv
// offset-mode synchronised 16-bit pwm timer with an axi4-lite register slave
// assumes the master offset match input is a pulse from logic on CLK_SYS_I
//
// Contract
// - With mode 00 the counter ignores other timers, runs from enable set until enable clear.
// - In independent mode each period event clears the counter, which keeps counting.
// - With mode 01 the counter holds until a master offset match, then runs until disabled.
// - In sync-start mode each period event clears the counter, which keeps counting.
// - With mode 10 the counter waits for a master match, then counts up from its value.
// - In one-shot mode a period event clears and halts the counter until the next match.
// - With mode 11 the counter stays inhibited after enable until the first master match.
// - In continuous-reset mode each later master match loads the counter with one.
// - In continuous-reset mode a period event before the match clears the counter.
// - Switching a running slave to independent mode keeps its present offset.
// - Center aligned, direction bit clear matches counting up, set matches counting down.
// - Outside center aligned operation the direction bit has no effect on matching.
// - The direction bit is double buffered and while running loads only after load arm.
`timescale 1ns/10ps
`default_nettype none
module pos_offset_sync (
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_I_UNUSED_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic MASTER_OFFSET_MATCH_I,
	output logic OFFSET_MATCH_O,
	output logic PWM_O,
	output logic [15:0] PWM_COUNTER_O
);
	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic awready;
		logic aw_have;
		logic [5:0] aw_idx;
		logic wready;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic enable;
		logic [1:0] mode;
		logic center;
		logic dir_buf;
		logic dir_act;
		logic load_arm;
		logic [15:0] period_value;
		logic [15:0] offset_value;
		logic [15:0] phase_value;
		logic [7:0] div;
		logic [7:0] div_cnt;
		logic tick;
		logic [15:0] pwm_counter;
		logic count_down;
		pos_pkg::pos_state_t st;
		logic match_pend;
		logic ofs_match;
		logic pwm;
	} pos_state_reg_t;

	pos_state_reg_t s_reg;
	pos_state_reg_t s_next;
	pos_match_if mif ();

	pos_match_gen u_match (
		.mif(mif)
	);

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic idx_mapped(input logic [5:0] idx);
		return (idx == pos_pkg::IDX_CTRL) || (idx == pos_pkg::IDX_PERIOD) ||
			(idx == pos_pkg::IDX_OFFSET) || (idx == pos_pkg::IDX_PHASE) ||
			(idx == pos_pkg::IDX_STATUS) || (idx == pos_pkg::IDX_DIV);
	endfunction

	logic per_evt;
	logic turn_down;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;
	logic [31:0] wr_val;
	logic [31:0] rd_val;

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[pos_pkg::CTRL_EN] = s_reg.enable;
		ctrl_word[pos_pkg::CTRL_MODE_LO +: 2] = s_reg.mode;
		ctrl_word[pos_pkg::CTRL_CENTER] = s_reg.center;
		ctrl_word[pos_pkg::CTRL_DIR] = s_reg.dir_buf;
		ctrl_word[pos_pkg::CTRL_LDA] = s_reg.load_arm;
		stat_word = {16'h0000, s_reg.pwm_counter};
		stat_word[pos_pkg::STAT_RUN] = (s_reg.st == pos_pkg::ST_RUN);
		stat_word[pos_pkg::STAT_DOWN] = s_reg.count_down;
		stat_word[pos_pkg::STAT_DIR] = s_reg.dir_act;
		stat_word[pos_pkg::STAT_WAIT] = (s_reg.st == pos_pkg::ST_WAIT);
	end

	// ***************************************************************
	// master side offset match
	// ***************************************************************
	assign mif.count = s_reg.pwm_counter;
	assign mif.offset = s_reg.offset_value;
	assign mif.count_down = s_reg.count_down;
	assign mif.center = s_reg.center;
	assign mif.dir_sel = s_reg.dir_act;
	assign mif.tick = s_reg.tick;
	assign mif.running = (s_reg.st == pos_pkg::ST_RUN);

	// ***************************************************************
	// period event and turn point
	// ***************************************************************
	always_comb begin
		if (s_reg.center) begin
			per_evt = s_reg.count_down && (s_reg.pwm_counter == 16'h0000);
			turn_down = !s_reg.count_down && (s_reg.pwm_counter == s_reg.period_value);
		end else begin
			per_evt = (s_reg.pwm_counter == s_reg.period_value);
			turn_down = 1'b0;
		end
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		s_next = s_reg;
		wr_val = 32'h0000_0000;
		rd_val = 32'h0000_0000;

		// tick divider
		s_next.tick = 1'b0;
		if (s_reg.div_cnt == 8'h00) begin
			s_next.div_cnt = s_reg.div;
			s_next.tick = 1'b1;
		end else begin
			s_next.div_cnt = s_reg.div_cnt - 8'h01;
		end

		// master match waits for the next tick; a new match wins over consumption
		if (s_reg.tick || !s_reg.enable) begin
			s_next.match_pend = 1'b0;
		end
		if (MASTER_OFFSET_MATCH_I) begin
			s_next.match_pend = 1'b1;
		end

		s_next.ofs_match = mif.match;

		// counter and mode sequencing
		if (!s_reg.enable) begin
			s_next.st = pos_pkg::ST_IDLE;
			s_next.pwm_counter = 16'h0000;
			s_next.count_down = 1'b0;
			s_next.pwm = 1'b0;
		end else begin
			unique case (s_reg.st)
				pos_pkg::ST_IDLE: begin
					if (s_reg.mode == pos_pkg::MODE_INDEP) begin
						s_next.st = pos_pkg::ST_RUN;
					end else begin
						s_next.st = pos_pkg::ST_WAIT;
					end
				end
				pos_pkg::ST_WAIT: begin
					if (s_reg.mode == pos_pkg::MODE_INDEP) begin
						s_next.st = pos_pkg::ST_RUN;
					end else if (s_reg.tick && s_reg.match_pend) begin
						s_next.st = pos_pkg::ST_RUN;
					end
				end
				pos_pkg::ST_RUN: begin
					if (s_reg.tick) begin
						if (s_reg.mode == pos_pkg::MODE_CONT_RESET && s_reg.match_pend) begin
							s_next.pwm_counter = pos_pkg::CNT_RELOAD_ONE;
							s_next.count_down = 1'b0;
						end else if (per_evt) begin
							s_next.pwm_counter = 16'h0000;
							s_next.count_down = 1'b0;
							s_next.pwm = 1'b0;
							if (s_reg.mode == pos_pkg::MODE_ONE_SHOT) begin
								s_next.st = pos_pkg::ST_WAIT;
							end
						end else if (turn_down) begin
							s_next.count_down = 1'b1;
							if (s_reg.pwm_counter != 16'h0000) begin
								s_next.pwm_counter = s_reg.pwm_counter - 16'h0001;
							end
						end else if (s_reg.count_down) begin
							s_next.pwm_counter = s_reg.pwm_counter - 16'h0001;
						end else begin
							s_next.pwm_counter = s_reg.pwm_counter + 16'h0001;
						end
						if (!per_evt && s_reg.pwm_counter == s_reg.phase_value) begin
							s_next.pwm = 1'b1;
						end
					end
				end
			endcase
		end

		// armed direction bit loads at the period event or while stopped
		if (s_reg.load_arm && ((s_reg.tick && per_evt) || !s_reg.enable)) begin
			s_next.dir_act = s_reg.dir_buf;
			s_next.load_arm = 1'b0;
		end

		// write address and data channels, taken in either order
		if (AWVALID_I && s_reg.awready) begin
			s_next.aw_have = 1'b1;
			s_next.aw_idx = AWADDR_I[7:2];
			s_next.awready = 1'b0;
		end
		if (WVALID_I && s_reg.wready) begin
			s_next.w_have = 1'b1;
			s_next.wdata = WDATA_I;
			s_next.wstrb = WSTRB_I;
			s_next.wready = 1'b0;
		end

		// register write once both halves are in
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = idx_mapped(s_reg.aw_idx) ? pos_pkg::RESP_OKAY : pos_pkg::RESP_SLVERR;
			unique case (s_reg.aw_idx)
				pos_pkg::IDX_CTRL: begin
					wr_val = merge_bytes(ctrl_word, s_reg.wdata, s_reg.wstrb);
					s_next.enable = wr_val[pos_pkg::CTRL_EN];
					s_next.mode = wr_val[pos_pkg::CTRL_MODE_LO +: 2];
					s_next.center = wr_val[pos_pkg::CTRL_CENTER];
					s_next.dir_buf = wr_val[pos_pkg::CTRL_DIR];
					if (!s_reg.enable) begin
						s_next.dir_act = wr_val[pos_pkg::CTRL_DIR];
					end
					if (s_reg.wstrb[0] && s_reg.wdata[pos_pkg::CTRL_LDA]) begin
						s_next.load_arm = 1'b1;
					end
				end
				pos_pkg::IDX_PERIOD: begin
					wr_val = merge_bytes({16'h0000, s_reg.period_value}, s_reg.wdata, s_reg.wstrb);
					s_next.period_value = wr_val[15:0];
				end
				pos_pkg::IDX_OFFSET: begin
					wr_val = merge_bytes({16'h0000, s_reg.offset_value}, s_reg.wdata, s_reg.wstrb);
					s_next.offset_value = wr_val[15:0];
				end
				pos_pkg::IDX_PHASE: begin
					wr_val = merge_bytes({16'h0000, s_reg.phase_value}, s_reg.wdata, s_reg.wstrb);
					s_next.phase_value = wr_val[15:0];
				end
				pos_pkg::IDX_DIV: begin
					wr_val = merge_bytes({24'h000000, s_reg.div}, s_reg.wdata, s_reg.wstrb);
					s_next.div = wr_val[7:0];
				end
				default: begin
					wr_val = 32'h0000_0000;
				end
			endcase
		end

		// write response
		if (s_reg.bvalid && BREADY_I) begin
			s_next.bvalid = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end

		// read channel
		if (ARVALID_I && s_reg.arready) begin
			unique case (ARADDR_I[7:2])
				pos_pkg::IDX_CTRL: rd_val = ctrl_word;
				pos_pkg::IDX_PERIOD: rd_val = {16'h0000, s_reg.period_value};
				pos_pkg::IDX_OFFSET: rd_val = {16'h0000, s_reg.offset_value};
				pos_pkg::IDX_PHASE: rd_val = {16'h0000, s_reg.phase_value};
				pos_pkg::IDX_STATUS: rd_val = stat_word;
				pos_pkg::IDX_DIV: rd_val = {24'h000000, s_reg.div};
				default: rd_val = 32'h0000_0000;
			endcase
			s_next.arready = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_val;
			s_next.rresp = idx_mapped(ARADDR_I[7:2]) ? pos_pkg::RESP_OKAY : pos_pkg::RESP_SLVERR;
		end
		if (s_reg.rvalid && RREADY_I) begin
			s_next.rvalid = 1'b0;
			s_next.arready = 1'b1;
		end
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.period_value <= pos_pkg::PERIOD_RST;
			s_reg.offset_value <= pos_pkg::OFFSET_RST;
			s_reg.phase_value <= pos_pkg::PHASE_RST;
			s_reg.div <= pos_pkg::DIV_RST;
			s_reg.st <= pos_pkg::ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign AWREADY_O = s_reg.awready;
	assign WREADY_O = s_reg.wready;
	assign BVALID_O = s_reg.bvalid;
	assign BRESP_O = s_reg.bresp;
	assign ARREADY_O = s_reg.arready;
	assign RVALID_O = s_reg.rvalid;
	assign RDATA_I_UNUSED_O = s_reg.rdata;
	assign RRESP_O = s_reg.rresp;
	assign OFFSET_MATCH_O = s_reg.ofs_match;
	assign PWM_O = s_reg.pwm;
	assign PWM_COUNTER_O = s_reg.pwm_counter;
endmodule // pos_offset_sync
`default_nettype wire

// file: pos_pkg.sv
// constants and types shared by the offset-sync timer files
// assumes one 100 MHz system clock and a 32-bit register bus
package pos_pkg;
	// ***************************************************************
	// bus layout
	// ***************************************************************
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_PERIOD = 6'h01;
	localparam logic [5:0] IDX_OFFSET = 6'h02;
	localparam logic [5:0] IDX_PHASE = 6'h03;
	localparam logic [5:0] IDX_STATUS = 6'h04;
	localparam logic [5:0] IDX_DIV = 6'h05;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ***************************************************************
	// control register fields
	// ***************************************************************
	localparam int CTRL_EN = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_CENTER = 3;
	localparam int CTRL_DIR = 4;
	localparam int CTRL_LDA = 5;

	// ***************************************************************
	// status register fields
	// ***************************************************************
	localparam int STAT_RUN = 16;
	localparam int STAT_DOWN = 17;
	localparam int STAT_DIR = 18;
	localparam int STAT_WAIT = 19;

	// ***************************************************************
	// reset and reload values
	// ***************************************************************
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] PHASE_RST = 16'h0000;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [15:0] CNT_RELOAD_ONE = 16'h0001;

	// ***************************************************************
	// modes and states
	// ***************************************************************
	typedef enum logic [1:0] {
		MODE_INDEP = 2'h0,
		MODE_SYNC_START = 2'h1,
		MODE_ONE_SHOT = 2'h2,
		MODE_CONT_RESET = 2'h3
	} pos_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_RUN
	} pos_state_t;
endpackage

// file: pos_match_if.sv
// carrier between the timer core and its offset match generator
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface pos_match_if;
	logic [15:0] count;
	logic [15:0] offset;
	logic count_down;
	logic center;
	logic dir_sel;
	logic tick;
	logic running;
	logic match;
	modport gen (
		input count, offset, count_down, center, dir_sel, tick, running,
		output match
	);
	modport core (
		output count, offset, count_down, center, dir_sel, tick, running,
		input match
	);
endinterface
`default_nettype wire

// file: pos_match_gen.sv
// offset match decision of this timer acting as a master
// assumes the core registers the match before it leaves the block
`timescale 1ns/10ps
`default_nettype none
module pos_match_gen (
	pos_match_if.gen mif
);
	// ***************************************************************
	// match on equal count, direction-qualified when center aligned
	// ***************************************************************
	logic dir_ok;
	always_comb begin
		if (mif.center) begin
			dir_ok = (mif.count_down == mif.dir_sel);
		end else begin
			dir_ok = 1'b1;
		end
	end
	assign mif.match = mif.tick & mif.running & (mif.count == mif.offset) & dir_ok;
endmodule // pos_match_gen
`default_nettype wire

// file: pos_offset_sync_asserts.sv
// concurrent checks on the ports of the offset-sync timer
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module pos_offset_sync_asserts (
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic [1:0] BRESP_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_I_UNUSED_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic OFFSET_MATCH_O,
	input wire logic [15:0] PWM_COUNTER_O
);
	// ***************************************************************
	// handshake steps
	// ***************************************************************
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (SYS_RST_I);
	sequence s_wr_take;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence s_wr_done;
		BVALID_O && BREADY_I;
	endsequence
	sequence s_rd_take;
		ARVALID_I && ARREADY_O;
	endsequence
	// ***************************************************************
	// checks
	// ***************************************************************
	a_write_answer: assert property (s_wr_take |-> ##2 BVALID_O)
		else $error("write response late");
	a_write_block: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
		else $error("write accepted while response pending");
	a_write_back: assert property (s_wr_done |=> !BVALID_O && AWREADY_O && WREADY_O)
		else $error("write channel not freed after response");
	a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped early");
	a_read_answer: assert property (s_rd_take |=> RVALID_O && !ARREADY_O)
		else $error("read data late");
	a_read_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_I_UNUSED_O))
		else $error("read data dropped early");
	a_read_back: assert property (RVALID_O && RREADY_I |=> !RVALID_O && ARREADY_O)
		else $error("read channel not freed");
	a_match_pulse: assert property (OFFSET_MATCH_O |=> !OFFSET_MATCH_O)
		else $error("offset match longer than one cycle");
	a_count_step: assert property ($changed(PWM_COUNTER_O) |->
		PWM_COUNTER_O == $past(PWM_COUNTER_O) + 16'h0001 || PWM_COUNTER_O == 16'h0000
		|| PWM_COUNTER_O == 16'h0001 || PWM_COUNTER_O == $past(PWM_COUNTER_O) - 16'h0001)
		else $error("counter jumped");
endmodule // pos_offset_sync_asserts
bind pos_offset_sync pos_offset_sync_asserts i_pos_offset_sync_asserts (
	.CLK_SYS_I, .SYS_RST_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BRESP_O,
	.BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RDATA_I_UNUSED_O, .RVALID_O,
	.RREADY_I, .OFFSET_MATCH_O, .PWM_COUNTER_O
);
`default_nettype wire

// file: pos_master_model.sv
// master timer model: counter that pulses its offset match once a period
// assumes it runs on the slave's system clock
`timescale 1ns/10ps
`default_nettype none
module pos_master_model #(
	parameter logic [15:0] PERIOD = 16'h0009,
	parameter logic [15:0] OFFSET = 16'h0003
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	output logic match_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic match;
	} pos_mstate_t;
	pos_mstate_t st_reg;
	pos_mstate_t st_next;
	// ***************************************************************
	// counter and match
	// ***************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.match = 1'b0;
		if (en_i) begin
			st_next.cnt = (st_reg.cnt == PERIOD) ? 16'h0000 : st_reg.cnt + 16'h0001;
			st_next.match = (st_reg.cnt == OFFSET);
		end
	end
	// same clock as the slave, never faster
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign match_o = st_reg.match;
endmodule // pos_master_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench: register rows, then offset-mode and direction scenarios
// assumes the master model shares the 100 MHz system clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic wr;
		logic [5:0] idx;
		logic [31:0] data;
		logic [3:0] strb;
		logic [31:0] exp;
		logic [1:0] resp;
	} pos_row_t;
	localparam logic [1:0] OK = pos_pkg::RESP_OKAY;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, m_en;
	logic awready, wready, bvalid, arready, rvalid, match_in, match_out, pwm;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [15:0] cnt, mx, mn;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	pos_row_t rows [10];
	pos_offset_sync i_pos_offset_sync (.CLK_SYS_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr),
		.AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
		.BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_I_UNUSED_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.MASTER_OFFSET_MATCH_I(match_in), .OFFSET_MATCH_O(match_out), .PWM_O(pwm),
		.PWM_COUNTER_O(cnt));
	pos_master_model i_pos_master_model (.clk_i(clk), .rst_i(rst), .en_i(m_en), .match_o(match_in));
	// ***************************************************************
	// helpers
	// ***************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] cv(input logic en, input logic [1:0] m, input logic c,
			input logic dr, input logic ld);
		cv = '0;
		cv[pos_pkg::CTRL_EN] = en;
		cv[pos_pkg::CTRL_MODE_LO +: 2] = m;
		cv[pos_pkg::CTRL_CENTER] = c;
		cv[pos_pkg::CTRL_DIR] = dr;
		cv[pos_pkg::CTRL_LDA] = ld;
	endfunction
	// response ready is raised late so the slave must hold its answer
	task automatic wr(input logic [5:0] idx, input logic [31:0] v, input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (n == 4) bready <= 1'b1;
			n++;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic cw(input logic [31:0] v);
		wr(pos_pkg::IDX_CTRL, v);
	endtask
	task automatic rd(input logic [5:0] idx);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (n == 3) rready <= 1'b1;
			n++;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_cnt(input logic [15:0] v);
		int n;
		n = 0;
		while (cnt !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(n < 200, 32'h1);
	endtask
	// up: the match must come while the counter is above the offset of 3
	task automatic mt(input logic up);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (match_out !== 1'b1 && n < 200);
		chk(match_out, 32'h1);
		chk(cnt > 16'h0003, up);
	endtask
	// ***************************************************************
	// sequence
	// ***************************************************************
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, m_en} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		rows = '{
			'{1'b0, pos_pkg::IDX_PERIOD, 32'h0, 4'hF, {16'h0, pos_pkg::PERIOD_RST}, OK},
			'{1'b0, pos_pkg::IDX_OFFSET, 32'h0, 4'hF, {16'h0, pos_pkg::OFFSET_RST}, OK},
			'{1'b0, pos_pkg::IDX_PHASE, 32'h0, 4'hF, {16'h0, pos_pkg::PHASE_RST}, OK},
			'{1'b0, pos_pkg::IDX_DIV, 32'h0, 4'hF, {24'h0, pos_pkg::DIV_RST}, OK},
			'{1'b1, pos_pkg::IDX_PERIOD, 32'h0000ABCD, 4'hF, 32'h0000ABCD, OK},
			'{1'b1, pos_pkg::IDX_OFFSET, 32'h00001234, 4'hF, 32'h00001234, OK},
			'{1'b1, pos_pkg::IDX_OFFSET, 32'h0000BEEF, 4'h1, 32'h000012EF, OK},
			'{1'b1, pos_pkg::IDX_DIV, 32'h00000003, 4'hF, 32'h00000003, OK},
			'{1'b1, pos_pkg::IDX_STATUS, 32'hFFFFFFFF, 4'hF, 32'h0, OK},
			'{1'b1, 6'h06, 32'h5A5A5A5A, 4'hF, 32'h0, pos_pkg::RESP_SLVERR}};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].idx, rows[i].data, rows[i].strb);
				chk(r, rows[i].resp);
			end
			rd(rows[i].idx);
			chk(d, rows[i].exp);
			chk(r, rows[i].resp);
		end
		wr(pos_pkg::IDX_DIV, 32'h0);
		wr(pos_pkg::IDX_PERIOD, 32'h4);
		m_en <= 1'b1;
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b0, 1'b0, 1'b0));
		wait_cnt(16'h4);
		@(posedge clk);
		chk(cnt, 32'h0);
		m_en <= 1'b0;
		cw(32'h0);
		cw(cv(1'b1, pos_pkg::MODE_SYNC_START, 1'b0, 1'b0, 1'b0));
		repeat (20) @(posedge clk);
		chk(cnt, 32'h0);
		rd(pos_pkg::IDX_STATUS);
		chk(d, 32'h0000_0001 << pos_pkg::STAT_WAIT);
		m_en <= 1'b1;
		wait_cnt(16'h4);
		@(posedge clk);
		chk(cnt, 32'h0);
		cw(32'h0);
		cw(cv(1'b1, pos_pkg::MODE_ONE_SHOT, 1'b0, 1'b0, 1'b0));
		wait_cnt(16'h2);
		m_en <= 1'b0;
		wait_cnt(16'h4);
		@(posedge clk);
		chk(cnt, 32'h0);
		repeat (15) @(posedge clk);
		chk(cnt, 32'h0);
		m_en <= 1'b1;
		wait_cnt(16'h3);
		m_en <= 1'b0;
		cw(32'h0);
		wr(pos_pkg::IDX_PERIOD, 32'h40);
		wr(pos_pkg::IDX_PHASE, 32'h1);
		cw(cv(1'b1, pos_pkg::MODE_CONT_RESET, 1'b0, 1'b0, 1'b0));
		repeat (12) @(posedge clk);
		chk(cnt, 32'h0);
		m_en <= 1'b1;
		repeat (30) @(posedge clk);
		mx = 16'h0000;
		mn = 16'hFFFF;
		repeat (40) begin
			@(posedge clk);
			if (cnt > mx) mx = cnt;
			if (cnt < mn) mn = cnt;
		end
		chk(mn, 32'h1);
		chk(mx < 16'h000D, 32'h1);
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b0, 1'b0, 1'b0));
		chk(cnt !== 16'h0, 32'h1);
		chk(pwm, 32'h1);
		cw(32'h0);
		wr(pos_pkg::IDX_PERIOD, 32'h6);
		wr(pos_pkg::IDX_OFFSET, 32'h3);
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b1, 1'b0, 1'b0));
		mt(1'b1);
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b1, 1'b1, 1'b0));
		repeat (30) @(posedge clk);
		mt(1'b1);
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b1, 1'b1, 1'b1));
		repeat (30) @(posedge clk);
		mt(1'b0);
		cw(32'h0);
		cw(cv(1'b1, pos_pkg::MODE_INDEP, 1'b0, 1'b1, 1'b0));
		mt(1'b1);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk(cnt, 32'h0);
		rd(pos_pkg::IDX_PERIOD);
		chk(d, {16'h0, pos_pkg::PERIOD_RST});
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
